// ---- inc/fpp_pkg.sv ----
// Constants for the flash protection and programming-entry block.
// Assumes a 32-bit AHB-Lite register bus.
package fpp_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_TRG_LOW = 8'h00;
    localparam logic [7:0] OFS_TRG_HIGH = 8'h04;
    localparam logic [7:0] OFS_ID_LOW = 8'h08;
    localparam logic [7:0] OFS_ID_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CFG4L = 8'h10;
    localparam logic [7:0] OFS_PROTECT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_OPERAND = 8'h1C;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_B0_GUARD = 0;
    localparam int BIT_BOOT_GUARD = 6;
    localparam int BIT_SSP_EN = 2;
    localparam int BIT_SIZE_LO = 4;
    localparam int BIT_B0_CP = 0;
    localparam int BIT_BOOT_CP = 1;
    localparam int BIT_B0_WP = 2;
    localparam int BIT_BOOT_WP = 3;
    // ----------------------------------------
    // Reset values and CFG4L writable-bit mask, unimplemented bits read one
    // ----------------------------------------
    localparam logic [7:0] RST_TRG_LOW = 8'hFF;
    localparam logic [7:0] RST_TRG_HIGH = 8'hFF;
    localparam logic [7:0] RST_CFG4L = 8'hFF;
    localparam logic [7:0] RST_PROTECT = 8'hFF;
    localparam logic [7:0] MSK_CFG4L = 8'h34;
    // ----------------------------------------
    // Boot region end addresses per size code
    // ----------------------------------------
    localparam logic [21:0] BOOT_END_1K = 22'h0007FF;
    localparam logic [21:0] BOOT_END_2K = 22'h000FFF;
    localparam logic [21:0] BOOT_END_4K = 22'h001FFF;
    // ----------------------------------------
    // Serial link framing and commands
    // ----------------------------------------
    localparam int CMD_BITS = 4;
    localparam int OPND_BITS = 16;
    localparam logic [3:0] CMD_WR_CFG4L = 4'hC;
    typedef enum logic [1:0] {
        FPP_MODE_OFF,
        FPP_MODE_HV,
        FPP_MODE_LV
    } fpp_mode_e;
    typedef enum logic {
        FPP_SH_CMD,
        FPP_SH_OPND
    } fpp_shift_e;
endpackage : fpp_pkg

// ---- hdl/fpp_flash_protect.sv ----
// Flash table-read protection, part identity, programming-entry
// control and serial programming link capture, as an AHB-Lite slave.
// Assumes pins arrive asynchronous; table-read requests are on hclk.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module fpp_flash_protect #(
    parameter logic [10:0] PART_CODE = 11'h2A5, // Arbitrary value
    parameter logic [4:0] REVISION = 5'h03, // Arbitrary value
    parameter logic [21:0] BLOCK0_END = 22'h003FFF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic reset_highvolt_pin,
    input wire logic prog_select_pin,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data,
    input wire logic tblrd_valid,
    input wire logic [21:0] tblrd_addr,
    input wire logic [21:0] tblrd_exec_addr,
    output logic tblrd_done,
    output logic tblrd_refused,
    output logic prog_select_gpio_en,
    output logic [1:0] prog_mode
);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (BLOCK0_END <= fpp_pkg::BOOT_END_4K) begin : g_block0_end_check
        $error("BLOCK0_END must lie above the largest boot region");
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Region code: 0 boot, 1 block 0, 2 elsewhere
    function automatic logic [1:0] region_of(
        input logic [21:0] addr,
        input logic [21:0] boot_end
    );
        logic [1:0] r;
        r = 2'h2;
        if (addr <= boot_end) begin
            r = 2'h0;
        end else if (addr <= BLOCK0_END) begin
            r = 2'h1;
        end
        return r;
    endfunction : region_of

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] trg_low_reg;
    logic [7:0] trg_high_reg;
    logic [7:0] cfg4l_reg;
    logic [7:0] protect_reg;
    logic [7:0] cfg4l_next;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic pgc_prev_reg;
    fpp_pkg::fpp_mode_e mode_reg;
    fpp_pkg::fpp_mode_e mode_next;
    fpp_pkg::fpp_shift_e sh_state_reg;
    logic [15:0] shift_reg;
    logic [4:0] bit_cnt_reg;
    logic [3:0] cmd_reg;
    logic [15:0] operand_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic rd_pend_reg;
    logic [7:0] rd_addr_reg;
    logic hready_reg;
    logic [31:0] hrdata_reg;
    logic done_reg;
    logic refused_reg;
    logic gpio_en_reg;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire logic [3:0] pins_in = {prog_serial_data, prog_serial_clock,
                                prog_select_pin, reset_highvolt_pin};
    wire logic hv_s = sync2_reg[0];
    wire logic pgm_s = sync2_reg[1];
    wire logic pgc_s = sync2_reg[2];
    wire logic pgd_s = sync2_reg[3];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else if (clk_en) begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ----------------------------------------
    // Programming mode decode
    // ----------------------------------------
    wire logic ssp_en = cfg4l_reg[fpp_pkg::BIT_SSP_EN];
    wire logic is_hv = (mode_reg == fpp_pkg::FPP_MODE_HV);
    wire logic in_prog = (mode_reg != fpp_pkg::FPP_MODE_OFF);

    always_comb begin
        mode_next = fpp_pkg::FPP_MODE_OFF;
        if (hv_s) begin
            mode_next = fpp_pkg::FPP_MODE_HV;
        end else if (ssp_en && pgm_s) begin
            mode_next = fpp_pkg::FPP_MODE_LV;
        end
    end

    // ----------------------------------------
    // Serial link capture
    // ----------------------------------------
    wire logic pgc_fall = pgc_prev_reg && !pgc_s;
    wire logic [15:0] shift_next = {pgd_s, shift_reg[15:1]};
    wire logic cmd_last = (sh_state_reg == fpp_pkg::FPP_SH_CMD) &&
                          (bit_cnt_reg == 5'(fpp_pkg::CMD_BITS - 1));
    wire logic opnd_last = (sh_state_reg == fpp_pkg::FPP_SH_OPND) &&
                           (bit_cnt_reg == 5'(fpp_pkg::OPND_BITS - 1));
    wire logic ser_cfg_wr = in_prog && pgc_fall && opnd_last &&
                            is_hv && (cmd_reg == fpp_pkg::CMD_WR_CFG4L);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgc_prev_reg <= 1'b0;
            mode_reg <= fpp_pkg::FPP_MODE_OFF;
            sh_state_reg <= fpp_pkg::FPP_SH_CMD;
            shift_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
            cmd_reg <= 4'h0;
            operand_reg <= 16'h0000;
        end else if (clk_en) begin
            pgc_prev_reg <= pgc_s;
            mode_reg <= mode_next;
            if (!in_prog) begin
                sh_state_reg <= fpp_pkg::FPP_SH_CMD;
                bit_cnt_reg <= 5'h00;
            end else if (pgc_fall) begin
                shift_reg <= shift_next;
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if (cmd_last) begin
                    cmd_reg <= shift_next[15:12];
                    sh_state_reg <= fpp_pkg::FPP_SH_OPND;
                    bit_cnt_reg <= 5'h00;
                end else if (opnd_last) begin
                    operand_reg <= shift_next;
                    sh_state_reg <= fpp_pkg::FPP_SH_CMD;
                    bit_cnt_reg <= 5'h00;
                end
            end
        end
    end

    // ----------------------------------------
    // Protection and configuration write path
    // ----------------------------------------
    wire logic any_protect = (protect_reg[3:0] != 4'hF) ||
                             !trg_low_reg[fpp_pkg::BIT_B0_GUARD] ||
                             !trg_high_reg[fpp_pkg::BIT_BOOT_GUARD];
    wire logic bus_wr = wr_pend_reg;
    wire logic bus_cfg_wr = bus_wr && (wr_addr_reg == fpp_pkg::OFS_CFG4L);
    wire logic [7:0] operand_next_byte = shift_next[7:0];
    wire logic [7:0] cfg_src = ser_cfg_wr ? operand_next_byte : hwdata[7:0];
    wire logic [7:0] keep_lvp = is_hv ? 8'h00 : (8'h01 << fpp_pkg::BIT_SSP_EN);
    wire logic [7:0] keep_size = any_protect ? (8'h03 << fpp_pkg::BIT_SIZE_LO) : 8'h00;
    wire logic [7:0] keep_mask = keep_lvp | keep_size | ~fpp_pkg::MSK_CFG4L;

    always_comb begin
        cfg4l_next = cfg4l_reg;
        if (ser_cfg_wr || bus_cfg_wr) begin
            cfg4l_next = (cfg4l_reg & keep_mask) | (cfg_src & ~keep_mask);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trg_low_reg <= fpp_pkg::RST_TRG_LOW;
            trg_high_reg <= fpp_pkg::RST_TRG_HIGH;
            cfg4l_reg <= fpp_pkg::RST_CFG4L;
            protect_reg <= fpp_pkg::RST_PROTECT;
        end else if (clk_en) begin
            cfg4l_reg <= cfg4l_next;
            if (bus_wr && wr_addr_reg == fpp_pkg::OFS_TRG_LOW) begin
                trg_low_reg <= hwdata[7:0] | ~(8'h01 << fpp_pkg::BIT_B0_GUARD);
            end
            if (bus_wr && wr_addr_reg == fpp_pkg::OFS_TRG_HIGH) begin
                trg_high_reg <= hwdata[7:0] | ~(8'h01 << fpp_pkg::BIT_BOOT_GUARD);
            end
            if (bus_wr && wr_addr_reg == fpp_pkg::OFS_PROTECT) begin
                protect_reg <= hwdata[7:0] | 8'hF0;
            end
        end
    end

    // ----------------------------------------
    // Table-read guard
    // ----------------------------------------
    wire logic [1:0] size_sel = cfg4l_reg[fpp_pkg::BIT_SIZE_LO +: 2];
    wire logic [21:0] boot_end = size_sel[1] ? fpp_pkg::BOOT_END_4K :
                                 size_sel[0] ? fpp_pkg::BOOT_END_2K : fpp_pkg::BOOT_END_1K;
    wire logic [1:0] tgt_rgn = region_of(tblrd_addr, boot_end);
    wire logic [1:0] exe_rgn = region_of(tblrd_exec_addr, boot_end);
    wire logic foreign = (tgt_rgn != exe_rgn);
    wire logic deny_b0 = (tgt_rgn == 2'h1) && foreign &&
                         !trg_low_reg[fpp_pkg::BIT_B0_GUARD];
    wire logic deny_boot = (tgt_rgn == 2'h0) && foreign &&
                           !trg_high_reg[fpp_pkg::BIT_BOOT_GUARD];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            gpio_en_reg <= 1'b0;
        end else if (clk_en) begin
            done_reg <= tblrd_valid;
            refused_reg <= tblrd_valid && (deny_b0 || deny_boot);
            gpio_en_reg <= !ssp_en && (mode_next != fpp_pkg::FPP_MODE_LV);
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    wire logic addr_ok = hsel && htrans[1] && hready;
    wire logic [7:0] rd_sel = rd_addr_reg;
    wire logic [7:0] id_low = {PART_CODE[2:0], REVISION};
    wire logic [7:0] id_high = PART_CODE[10:3];
    wire logic [31:0] status_word = {24'h000000, cmd_reg, 2'b00, mode_reg};
    logic [31:0] rd_mux;

    always_comb begin
        case (rd_sel)
            fpp_pkg::OFS_TRG_LOW: rd_mux = {24'h000000, trg_low_reg};
            fpp_pkg::OFS_TRG_HIGH: rd_mux = {24'h000000, trg_high_reg};
            fpp_pkg::OFS_ID_LOW: rd_mux = {24'h000000, id_low};
            fpp_pkg::OFS_ID_HIGH: rd_mux = {24'h000000, id_high};
            fpp_pkg::OFS_CFG4L: rd_mux = {24'h000000, cfg4l_reg};
            fpp_pkg::OFS_PROTECT: rd_mux = {24'h000000, protect_reg};
            fpp_pkg::OFS_STATUS: rd_mux = status_word;
            fpp_pkg::OFS_OPERAND: rd_mux = {16'h0000, operand_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
            hready_reg <= 1'b1;
            hrdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            hready_reg <= !(addr_ok && !hwrite);
            if (addr_ok) begin
                wr_addr_reg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
                rd_addr_reg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
            end
            if (rd_pend_reg) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    assign hreadyout = hready_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign tblrd_done = done_reg;
    assign tblrd_refused = refused_reg;
    assign prog_select_gpio_en = gpio_en_reg;
    assign prog_mode = mode_reg;
endmodule : fpp_flash_protect

// ---- testbench/fpp_check_monitor.sv ----
// Port checker for the flash protection block.
// Assumes it is bound to every fpp_flash_protect instance.
`timescale 1ns/10ps
module fpp_check_monitor #(
    parameter logic [21:0] BLOCK0_END = 22'h003FFF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic tblrd_valid,
    input wire logic [21:0] tblrd_addr,
    input wire logic [21:0] tblrd_exec_addr,
    input wire logic tblrd_done,
    input wire logic tblrd_refused,
    input wire logic reset_highvolt_pin,
    input wire logic prog_select_gpio_en,
    input wire logic [1:0] prog_mode
);
    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    done_follows_a: assert property (tblrd_valid |=> tblrd_done)
        else $error("table read not answered next cycle");
    refuse_with_done_a: assert property (tblrd_refused |-> tblrd_done)
        else $error("refusal without completion");
    outside_block0_a: assert property (tblrd_valid && tblrd_addr > BLOCK0_END |=> !tblrd_refused)
        else $error("read above block0 refused");
    same_place_a: assert property (tblrd_valid && tblrd_addr == tblrd_exec_addr |=> !tblrd_refused)
        else $error("read from own region refused");
    hv_entry_a: assert property ((reset_highvolt_pin && clk_en) [*5] |-> prog_mode == 2'h1)
        else $error("high voltage entry not taken");
    lv_pin_kept_a: assert property (prog_mode == 2'h2 && $past(prog_mode) == 2'h2 |-> !prog_select_gpio_en)
        else $error("select pin freed in low voltage mode");
    mode_legal_a: assert property (prog_mode != 2'h3)
        else $error("illegal mode code");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite && clk_en |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite && clk_en |=> hreadyout)
        else $error("write stalled");
endmodule : fpp_check_monitor

bind fpp_flash_protect fpp_check_monitor #(.BLOCK0_END(BLOCK0_END)) u_fpp_check_monitor (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .tblrd_valid(tblrd_valid), .tblrd_addr(tblrd_addr),
    .tblrd_exec_addr(tblrd_exec_addr), .tblrd_done(tblrd_done), .tblrd_refused(tblrd_refused),
    .reset_highvolt_pin(reset_highvolt_pin), .prog_select_gpio_en(prog_select_gpio_en), .prog_mode(prog_mode));

// ---- testbench/fpp_programmer.sv ----
// Behavioural programmer driving the serial programming link and pins.
// Assumes the device samples data on falling clock edges.
`timescale 1ns/10ps
module fpp_programmer #(
    parameter int HALF_NS = 400,
    parameter int GAP_NS = 400,
    parameter int WRITE_WAIT_NS = 5000000,
    parameter int PROG_HIGH_NS = 1000000,
    parameter int DISCHARGE_NS = 100000
) (
    output logic prog_serial_clock,
    output logic prog_serial_data,
    output logic reset_highvolt_pin,
    output logic prog_select_pin
);
    initial begin
        prog_serial_clock = 1'b0;
        prog_serial_data = 1'b0;
        reset_highvolt_pin = 1'b0;
        prog_select_pin = 1'b0;
    end
    task automatic pins(input logic hv, input logic sel);
        reset_highvolt_pin = hv;
        prog_select_pin = sel;
    endtask : pins
    // Checksum helpers: 16-bit running sum, carries out of bit 15 lost
    function automatic logic [15:0] add_word(input logic [15:0] acc, input logic [15:0] w);
        return acc + w;
    endfunction : add_word
    function automatic logic [15:0] add_cfg(input logic [15:0] acc, input logic [7:0] cfg, input logic [7:0] mask);
        return acc + {8'h00, cfg & mask};
    endfunction : add_cfg
    function automatic logic [15:0] add_id(input logic [15:0] acc, input logic [15:0] id, input logic any_cp);
        return any_cp ? acc + id : acc;
    endfunction : add_id
    task automatic send(input logic [3:0] cmd, input logic [15:0] opnd, input logic timed);
        logic [19:0] frame;
        frame = {opnd, cmd};
        for (int i = 0; i < 20; i++) begin
            prog_serial_clock = 1'b1;
            prog_serial_data = frame[i];
            #(HALF_NS);
            if (timed && i == 3) #(PROG_HIGH_NS);
            prog_serial_clock = 1'b0;
            #(HALF_NS);
            if (timed && i == 3) #(DISCHARGE_NS);
            if (i == 3) #(GAP_NS);
        end
        prog_serial_data = ~prog_serial_data;
        #(WRITE_WAIT_NS);
    endtask : send
endmodule : fpp_programmer

// ---- testbench/test_flash_protect_program_checksum.sv ----
// Self-checking bench for the flash protection block.
// Assumes the checker is bound and the programmer model drives the link.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module test_flash_protect_program_checksum;
    localparam logic [10:0] PCODE = 11'h5C3; // Arbitrary part code
    localparam logic [4:0] REV = 5'h11; // Arbitrary revision
    logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0, tblrd_valid = 0, rd_ph = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'hff9b;
    logic [1:0] htrans = 0, prog_mode;
    logic [2:0] hsize = 0;
    logic [21:0] tblrd_addr = 0, tblrd_exec_addr = 0;
    logic [15:0] opnd, csum;
    wire hready, hreadyout, hresp, tblrd_done, tblrd_refused, prog_select_gpio_en;
    wire sclk, sdat, hv_pin, sel_pin;
    logic [39:0] rq[$];
    logic tq[$];
    int bad_count = 0, compares = 0, cyc = 0;
    assign hready = hreadyout;
    always #50 hclk = ~hclk;
    fpp_flash_protect #(.PART_CODE(PCODE), .REVISION(REV), .BLOCK0_END(22'h003FFF)) u_fpp_flash_protect (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .reset_highvolt_pin(hv_pin), .prog_select_pin(sel_pin), .prog_serial_clock(sclk),
        .prog_serial_data(sdat), .tblrd_valid(tblrd_valid), .tblrd_addr(tblrd_addr),
        .tblrd_exec_addr(tblrd_exec_addr), .tblrd_done(tblrd_done), .tblrd_refused(tblrd_refused),
        .prog_select_gpio_en(prog_select_gpio_en), .prog_mode(prog_mode));
    // Self-timed write wait shortened to keep the run short
    fpp_programmer #(.WRITE_WAIT_NS(20000)) u_fpp_programmer (
        .prog_serial_clock(sclk), .prog_serial_data(sdat), .reset_highvolt_pin(hv_pin), .prog_select_pin(sel_pin));
    task give_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        rq.push_back({a, ex});
        bus(1'b0, a, 32'h00000000);
    endtask : rd
    function automatic logic [21:0] ra(input int r);
        logic [31:0] v;
        v = $random(seed);
        if (r == 0) return 22'(v % 32'h800);
        if (r == 1) return 22'(32'h800 + v % 32'h3800);
        if (r == 3) return 22'h000900;
        return 22'(32'h4000 + v % 32'h4000);
    endfunction : ra
    task automatic tr(input int ta, input int ea, input logic ex);
        @(posedge hclk);
        tblrd_valid <= 1'b1;
        tblrd_addr <= ra(ta);
        tblrd_exec_addr <= ra(ea);
        tq.push_back(ex);
        @(posedge hclk);
        tblrd_valid <= 1'b0;
        @(posedge hclk);
    endtask : tr
    task automatic settle;
        repeat (6) @(posedge hclk);
        #10;
    endtask : settle
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            give_verdict();
        end
        if (rd_ph && hreadyout === 1'b1) begin
            `CHK($sformatf("reg %h", rq[0][39:32]), rq[0][31:0], hrdata)
            void'(rq.pop_front());
            rd_ph = 0;
        end
        if (hsel && htrans[1] && hready && !hwrite) rd_ph = 1;
        if (tblrd_done === 1'b1) begin
            `CHK("refused", tq[0], tblrd_refused)
            void'(tq.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h00, 32'h000000FF);
        rd(8'h04, 32'h000000FF);
        rd(8'h08, {24'h000000, PCODE[2:0], REV});
        rd(8'h0C, {24'h000000, PCODE[10:3]});
        rd(8'h10, 32'h000000FF);
        rd(8'h14, 32'h000000FF);
        rd(8'h40, 32'h00000000);
        bus(1'b1, 8'h10, 32'h00000000);
        rd(8'h10, 32'h000000CF);
        u_fpp_programmer.pins(1'b0, 1'b1);
        settle();
        `CHK("mode", 2'h2, prog_mode)
        `CHK("gpio_en", 1'b0, prog_select_gpio_en)
        bus(1'b1, 8'h00, $random(seed) & 32'hFFFFFFFE);
        bus(1'b1, 8'h04, $random(seed) & 32'hFFFFFFBF);
        rd(8'h00, 32'h000000FE);
        rd(8'h04, 32'h000000BF);
        tr(1, 0, 1'b1);
        tr(1, 1, 1'b0);
        tr(0, 1, 1'b1);
        tr(0, 0, 1'b0);
        tr(2, 0, 1'b0);
        bus(1'b1, 8'h10, 32'h00000030);
        rd(8'h10, 32'h000000CF);
        tr(3, 0, 1'b1);
        u_fpp_programmer.pins(1'b1, 1'b0);
        settle();
        `CHK("mode", 2'h1, prog_mode)
        opnd = $random(seed);
        opnd[2] = 1'b0;
        u_fpp_programmer.send(4'hC, opnd, 1'b0);
        rd(8'h1C, {16'h0000, opnd});
        rd(8'h18, 32'h000000C1);
        rd(8'h10, 32'h000000CB);
        opnd = $random(seed);
        u_fpp_programmer.send(4'h0, opnd, 1'b1);
        rd(8'h1C, {16'h0000, opnd});
        rd(8'h18, 32'h00000001);
        rd(8'h10, 32'h000000CB);
        csum = u_fpp_programmer.add_word(16'hFFFF, 16'h0003);
        csum = u_fpp_programmer.add_cfg(csum, 8'hCF, fpp_pkg::MSK_CFG4L);
        csum = u_fpp_programmer.add_id(csum, 16'h0100, 1'b1);
        csum = u_fpp_programmer.add_id(csum, 16'h0200, 1'b0);
        `CHK("checksum", 16'h0106, csum)
        u_fpp_programmer.pins(1'b0, 1'b1);
        settle();
        `CHK("mode", 2'h0, prog_mode)
        `CHK("gpio_en", 1'b1, prog_select_gpio_en)
        u_fpp_programmer.pins(1'b1, 1'b1);
        settle();
        `CHK("mode", 2'h1, prog_mode)
        `CHK("pending", 0, rq.size() + tq.size())
        give_verdict();
    end
endmodule : test_flash_protect_program_checksum
